// file: common/ocs_pkg.sv
package ocs_pkg;

  // Phase count, delay counter width and bus address width.
  localparam int unsigned NUM_PHASES = 3;
  localparam int unsigned DLY_W      = 16;
  localparam int unsigned ADR_W      = 8;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_ALARM_DLY  = 8'h04;
  localparam logic [7:0] ADDR_FAULT_DLY  = 8'h08;
  localparam logic [7:0] ADDR_STAGE_EN   = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS      = 8'h10;
  localparam logic [7:0] ADDR_LATEST_CUR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;

  // Field positions inside the flags register.
  localparam int unsigned FLAGS_ALARM_LSB = 0;
  localparam int unsigned FLAGS_START_BIT = 3;
  localparam int unsigned FLAGS_FAULT_LSB = 4;
  localparam int unsigned FLAGS_TRIP_BIT  = 7;

  // Reset values.
  localparam logic [15:0] ALARM_DLY_RST = 16'h0000;
  localparam logic [15:0] FAULT_DLY_RST = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RST  = 16'h0000;
  localparam logic [8:0]  CTRL_RST      = 9'h000;

  // Control register layout, bit 0 first from the bottom.
  typedef struct packed {
    logic repeat_event_select;
    logic combined_trip_off_event_enable;
    logic combined_trip_on_event_enable;
    logic phase_fault_off_event_enable;
    logic phase_fault_on_event_enable;
    logic combined_start_off_event_enable;
    logic combined_start_on_event_enable;
    logic phase_alarm_off_event_enable;
    logic phase_alarm_on_event_enable;
  } ctrl_t;

  // Event vector, also the layout of the interrupt status and mask.
  typedef struct packed {
    logic       trip_off;
    logic       trip_on;
    logic [2:0] fault_off;
    logic [2:0] fault_on;
    logic       start_off;
    logic       start_on;
    logic [2:0] alarm_off;
    logic [2:0] alarm_on;
  } event_t;

endpackage

// file: src/combined_overcurrent_status.sv
`timescale 1ns/10ps
module combined_overcurrent_status
  import ocs_pkg::*;
#(
  parameter int unsigned N_STAGES = 4,
  parameter int unsigned CUR_W    = 16
) (
  // Clock and reset
  input  wire logic                          REF_CLK,
  input  wire logic                          RST_N,
  // Stage inputs, three phase bits per stage
  input  wire logic [N_STAGES*3-1:0]         STAGE_START,
  input  wire logic [N_STAGES*3-1:0]         STAGE_TRIP,
  input  wire logic [N_STAGES*CUR_W-1:0]     STAGE_FAULT_CURRENT,
  input  wire logic                          SECOND_TICK,
  // Wishbone slave
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [ocs_pkg::ADR_W-1:0]     WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [31:0]                   WB_DAT_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  // Status flags
  output logic                               PHASE_A_ALARM_FLAG,
  output logic                               PHASE_B_ALARM_FLAG,
  output logic                               PHASE_C_ALARM_FLAG,
  output logic                               COMBINED_START_FLAG,
  output logic                               PHASE_A_FAULT_FLAG,
  output logic                               PHASE_B_FAULT_FLAG,
  output logic                               PHASE_C_FAULT_FLAG,
  output logic                               COMBINED_TRIP_FLAG,
  // Events to the logger and interrupt
  output ocs_pkg::event_t                    EVENTS,
  output logic      [CUR_W-1:0]              LATEST_FAULT_CURRENT,
  output logic                               IRQ
);

  localparam int unsigned NFLAG = 2 * NUM_PHASES;

  ctrl_t                   ctrl_reg;
  logic [DLY_W-1:0]        alarm_dly_reg;
  logic [DLY_W-1:0]        fault_dly_reg;
  logic [N_STAGES-1:0]     stage_en_reg;
  logic [CUR_W-1:0]        latest_cur_reg;
  logic [CUR_W-1:0]        latest_cur_next;
  logic                    cur_capture;
  event_t                  irq_status_reg;
  event_t                  irq_status_next;
  event_t                  irq_mask_reg;
  event_t                  event_reg;
  event_t                  event_next;
  logic                    irq_reg;
  logic                    ack_reg;
  logic [31:0]             dat_reg;
  logic [N_STAGES*3-1:0]   start_prev_reg;
  logic [N_STAGES*3-1:0]   trip_prev_reg;
  logic [N_STAGES*3-1:0]   start_masked;
  logic [N_STAGES*3-1:0]   trip_masked;
  logic [2:0]              start_any;
  logic [2:0]              trip_any;
  logic [2:0]              new_start;
  logic [2:0]              new_trip;
  logic [NFLAG-1:0]        flag_reg;
  wire logic [NFLAG-1:0]   flag_next;
  wire logic [DLY_W-1:0]   cnt_val [NFLAG];
  logic [1:0]              comb_reg;
  logic [1:0]              comb_next;
  logic                    bus_req;
  logic                    bus_wr;
  logic                    rd_clear;
  logic [31:0]             rd_word;
  logic [31:0]             wr_word;

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Stage gathering

  always_comb begin
    start_any       = '0;
    trip_any        = '0;
    new_start       = '0;
    new_trip        = '0;
    cur_capture     = 1'b0;
    latest_cur_next = latest_cur_reg;
    for (int s = 0; s < N_STAGES; s++) begin
      for (int p = 0; p < 3; p++) begin
        start_masked[s*3+p] = STAGE_START[s*3+p] & stage_en_reg[s];
        trip_masked[s*3+p]  = STAGE_TRIP[s*3+p] & stage_en_reg[s];
        start_any[p] = start_any[p] | start_masked[s*3+p];
        trip_any[p]  = trip_any[p] | trip_masked[s*3+p];
        new_start[p] = new_start[p] | (start_masked[s*3+p] & ~start_prev_reg[s*3+p]);
        new_trip[p]  = new_trip[p] | (trip_masked[s*3+p] & ~trip_prev_reg[s*3+p]);
      end
      // A newly tripping enabled stage records its current; the highest stage wins a tie.
      if (|(trip_masked[s*3 +: 3] & ~trip_prev_reg[s*3 +: 3])) begin
        cur_capture     = 1'b1;
        latest_cur_next = STAGE_FAULT_CURRENT[s*CUR_W +: CUR_W];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_prev_reg <= '0;
      trip_prev_reg  <= '0;
    end else begin
      start_prev_reg <= start_masked;
      trip_prev_reg  <= trip_masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Stretched flags, alarm group first then fault group

  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    logic             src;
    logic [DLY_W-1:0] dly;
    logic             fnext;
    logic [DLY_W-1:0] cnt_reg;
    assign src = (i < 3) ? start_any[i % 3] : trip_any[i % 3];
    assign dly = (i < 3) ? alarm_dly_reg : fault_dly_reg;

    always_comb begin
      fnext = flag_reg[i];
      if (src) begin
        fnext = 1'b1;
      end else if (flag_reg[i] && cnt_reg >= dly) begin
        fnext = 1'b0;
      end
    end

    // The counter saturates, so a delay of 65535 never wraps back to an early clear.
    always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
        cnt_reg <= '0;
      end else if (src || !flag_reg[i]) begin
        cnt_reg <= '0;
      end else if (SECOND_TICK && cnt_reg != {DLY_W{1'b1}}) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end

    assign flag_next[i] = fnext;
    assign cnt_val[i]   = cnt_reg;
  end

  assign comb_next = {|flag_next[5:3], |flag_next[2:0]};

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= '0;
      comb_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      comb_reg <= comb_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Events

  // With repeats allowed, each further stage start or trip during an active flag
  // reports again; otherwise only the flag edges report, so on and off events pair.
  always_comb begin
    event_next = '0;
    for (int p = 0; p < 3; p++) begin
      event_next.alarm_on[p]  = ctrl_reg.phase_alarm_on_event_enable &
                                ((flag_next[p] & ~flag_reg[p]) |
                                 (ctrl_reg.repeat_event_select & flag_reg[p] & new_start[p]));
      event_next.alarm_off[p] = ctrl_reg.phase_alarm_off_event_enable &
                                (~flag_next[p] & flag_reg[p]);
      event_next.fault_on[p]  = ctrl_reg.phase_fault_on_event_enable &
                                ((flag_next[p+3] & ~flag_reg[p+3]) |
                                 (ctrl_reg.repeat_event_select & flag_reg[p+3] & new_trip[p]));
      event_next.fault_off[p] = ctrl_reg.phase_fault_off_event_enable &
                                (~flag_next[p+3] & flag_reg[p+3]);
    end
    event_next.start_on  = ctrl_reg.combined_start_on_event_enable &
                           ((comb_next[0] & ~comb_reg[0]) |
                            (ctrl_reg.repeat_event_select & comb_reg[0] & |new_start));
    event_next.start_off = ctrl_reg.combined_start_off_event_enable & ~comb_next[0] & comb_reg[0];
    event_next.trip_on   = ctrl_reg.combined_trip_on_event_enable &
                           ((comb_next[1] & ~comb_reg[1]) |
                            (ctrl_reg.repeat_event_select & comb_reg[1] & |new_trip));
    event_next.trip_off  = ctrl_reg.combined_trip_off_event_enable & ~comb_next[1] & comb_reg[1];
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      event_reg <= '0;
    end else begin
      event_reg <= event_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state

  // A write lands on the edge at which the master sees ack, so a request that is
  // abandoned before ack never changes a register; a read of the interrupt status clears it before ack.
  assign bus_req  = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign bus_wr   = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg;
  assign rd_clear = bus_req & ~WB_WE_I & (WB_ADR_I == ADDR_IRQ_STATUS);

  always_comb begin
    case (WB_ADR_I)
      ADDR_CTRL:       rd_word = 32'(ctrl_reg);
      ADDR_ALARM_DLY:  rd_word = 32'(alarm_dly_reg);
      ADDR_FAULT_DLY:  rd_word = 32'(fault_dly_reg);
      ADDR_STAGE_EN:   rd_word = 32'(stage_en_reg);
      ADDR_FLAGS:      rd_word = 32'({comb_reg[1], flag_reg[5:3], comb_reg[0], flag_reg[2:0]});
      ADDR_LATEST_CUR: rd_word = 32'(latest_cur_reg);
      ADDR_IRQ_STATUS: rd_word = 32'(irq_status_reg);
      ADDR_IRQ_MASK:   rd_word = 32'(irq_mask_reg);
      default:         rd_word = 32'h00000000;
    endcase
  end

  assign wr_word = merge_sel(rd_word, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg      <= CTRL_RST;
      alarm_dly_reg <= ALARM_DLY_RST;
      fault_dly_reg <= FAULT_DLY_RST;
      stage_en_reg  <= '0;
      irq_mask_reg  <= IRQ_MASK_RST;
    end else if (bus_wr) begin
      case (WB_ADR_I)
        ADDR_CTRL:      ctrl_reg      <= ctrl_t'(wr_word[8:0]);
        ADDR_ALARM_DLY: alarm_dly_reg <= wr_word[DLY_W-1:0];
        ADDR_FAULT_DLY: fault_dly_reg <= wr_word[DLY_W-1:0];
        ADDR_STAGE_EN:  stage_en_reg  <= wr_word[N_STAGES-1:0];
        ADDR_IRQ_MASK:  irq_mask_reg  <= event_t'(wr_word[15:0]);
        default: begin
        end
      endcase
    end
  end

  // A fresh trip outranks a software write in the same cycle.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      latest_cur_reg <= '0;
    end else if (cur_capture) begin
      latest_cur_reg <= latest_cur_next;
    end else if (bus_wr && WB_ADR_I == ADDR_LATEST_CUR) begin
      latest_cur_reg <= wr_word[CUR_W-1:0];
    end
  end

  // Reading the status clears it, but an event landing in that cycle survives.
  assign irq_status_next = (rd_clear ? event_t'('0) : irq_status_reg) | event_next;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_status_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_reg        <= |(irq_status_next & irq_mask_reg);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= 32'h00000000;
      if (bus_req && !WB_WE_I) begin
        dat_reg <= rd_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign WB_DAT_O             = dat_reg;
  assign WB_ACK_O             = ack_reg;
  assign PHASE_A_ALARM_FLAG   = flag_reg[0];
  assign PHASE_B_ALARM_FLAG   = flag_reg[1];
  assign PHASE_C_ALARM_FLAG   = flag_reg[2];
  assign COMBINED_START_FLAG  = comb_reg[0];
  assign PHASE_A_FAULT_FLAG   = flag_reg[3];
  assign PHASE_B_FAULT_FLAG   = flag_reg[4];
  assign PHASE_C_FAULT_FLAG   = flag_reg[5];
  assign COMBINED_TRIP_FLAG   = comb_reg[1];
  assign EVENTS               = event_reg;
  assign LATEST_FAULT_CURRENT = latest_cur_reg;
  assign IRQ                  = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_comb_start_or: assert property (COMBINED_START_FLAG == |flag_reg[2:0])
    else $error("combined start flag differs from OR of alarm flags");
  chk_comb_trip_or: assert property (COMBINED_TRIP_FLAG == |flag_reg[5:3])
    else $error("combined trip flag differs from OR of fault flags");
  chk_alarm_set_start: assert property (start_any[0] |=> PHASE_A_ALARM_FLAG)
    else $error("phase a alarm flag not set by start");
  chk_fault_set_trip: assert property (trip_any[1] |=> PHASE_B_FAULT_FLAG)
    else $error("phase b fault flag not set by trip");
  chk_alarm_clear_delay: assert property ($fell(flag_reg[0]) |->
      $past(!start_any[0] && cnt_val[0] >= alarm_dly_reg))
    else $error("alarm flag cleared before its delay");
  chk_fault_clear_delay: assert property ($fell(flag_reg[3]) |->
      $past(!trip_any[0] && cnt_val[3] >= fault_dly_reg))
    else $error("fault flag cleared before its delay");
  chk_disabled_stage_quiet: assert property ((stage_en_reg == '0) |-> (start_any == 3'b000 && trip_any == 3'b000))
    else $error("disabled stage contributed a flag");
  chk_alarm_on_enable: assert property (EVENTS.alarm_on != 3'b000 |-> $past(ctrl_reg.phase_alarm_on_event_enable))
    else $error("alarm on event without enable");
  chk_alarm_off_edge: assert property ($fell(flag_reg[0]) |->
      EVENTS.alarm_off[0] == $past(ctrl_reg.phase_alarm_off_event_enable))
    else $error("alarm off event does not match enable at falling edge");
  chk_paired_events: assert property ((EVENTS.alarm_on[0] && !$past(ctrl_reg.repeat_event_select)) |->
      $rose(flag_reg[0]))
    else $error("unpaired alarm on event while repeats suppressed");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

endmodule // combined_overcurrent_status

// file: verification/overcurrent_stage_model.sv
`timescale 1ns/10ps
module overcurrent_stage_model #(
  parameter int unsigned N_STAGES = 2,
  parameter int unsigned CUR_W    = 16
) (
  // Clock and bench commands
  input  wire logic                      clk,
  input  wire logic [N_STAGES*3-1:0]     start_cmd,
  input  wire logic [N_STAGES*3-1:0]     trip_cmd,
  input  wire logic [N_STAGES*CUR_W-1:0] cur_cmd,
  // Stage outputs
  output logic      [N_STAGES*3-1:0]     start_out,
  output logic      [N_STAGES*3-1:0]     trip_out,
  output logic      [N_STAGES*CUR_W-1:0] cur_out
);
  logic toggle = 1'b0;

  always @(posedge clk) begin
    toggle <= ~toggle;
  end

  // A stage that is not tripping does not hold a current value, so its lines change every cycle.
  always_comb begin
    start_out = start_cmd;
    trip_out  = trip_cmd;
    for (int s = 0; s < N_STAGES; s++) begin
      cur_out[s*CUR_W +: CUR_W] = (|trip_cmd[s*3 +: 3]) ? cur_cmd[s*CUR_W +: CUR_W] : {CUR_W{toggle}};
    end
  end
endmodule // overcurrent_stage_model

// file: verification/combined_overcurrent_status_tb.sv
`timescale 1ns/10ps
module combined_overcurrent_status_tb;
  import ocs_pkg::*;
  localparam int unsigned NS = 2;
  localparam int unsigned CW = 16;
  localparam int          NR = 7;

  logic            clk, rst_n, tick, cyc, stb, we, ack, acc_clr, irq;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     wd, rdat, rd;
  logic [NS*3-1:0] st_cmd, tr_cmd, st, tr;
  logic [NS*CW-1:0] cu_cmd, cu;
  logic [CW-1:0]   latest;
  wire logic [7:0] fl;
  event_t          ev, acc;
  int              failures, tests_run;

  logic [7:0]  r_adr [NR] = '{ADDR_CTRL, ADDR_ALARM_DLY, ADDR_FAULT_DLY, ADDR_STAGE_EN, ADDR_IRQ_MASK,
                              ADDR_FLAGS, 8'h40};
  logic [31:0] r_wd  [NR] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0001_2345, 32'h0000_00FF, 32'hFFFF_FFFF,
                              32'h0000_00FF, 32'hFFFF_FFFF};
  logic [31:0] r_rd  [NR] = '{32'h0000_01FF, 32'h0000_FFFF, 32'h0000_2345, 32'h0000_0003, 32'h0000_FFFF,
                              32'h0000_0000, 32'h0000_0000};

  overcurrent_stage_model #(.N_STAGES(NS), .CUR_W(CW)) overcurrent_stage_model_inst (
    .clk(clk), .start_cmd(st_cmd), .trip_cmd(tr_cmd), .cur_cmd(cu_cmd),
    .start_out(st), .trip_out(tr), .cur_out(cu));

  combined_overcurrent_status #(.N_STAGES(NS), .CUR_W(CW)) combined_overcurrent_status_inst (
    .REF_CLK(clk), .RST_N(rst_n), .STAGE_START(st), .STAGE_TRIP(tr), .STAGE_FAULT_CURRENT(cu),
    .SECOND_TICK(tick), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .PHASE_A_ALARM_FLAG(fl[0]), .PHASE_B_ALARM_FLAG(fl[1]), .PHASE_C_ALARM_FLAG(fl[2]),
    .COMBINED_START_FLAG(fl[3]), .PHASE_A_FAULT_FLAG(fl[4]), .PHASE_B_FAULT_FLAG(fl[5]),
    .PHASE_C_FAULT_FLAG(fl[6]), .COMBINED_TRIP_FLAG(fl[7]),
    .EVENTS(ev), .LATEST_FAULT_CURRENT(latest), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Event pulses last one cycle, so they are gathered here and checked later.
  always @(posedge clk) begin
    acc <= acc_clr ? event_t'(16'h0000) : event_t'(acc | ev);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk1(ack, 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_tick();
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask

  task automatic clr();
    @(posedge clk) acc_clr <= 1'b1;
    @(posedge clk) acc_clr <= 1'b0;
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    conclude();
  end

  initial begin
    {rst_n, tick, cyc, stb, we, acc_clr} = '0;
    {adr, wd, st_cmd, tr_cmd, cu_cmd} = '0;
    sel = 4'hF;
    failures = 0;
    tests_run = 0;
    cycles(1);
    chk32(32'({fl, ev, irq}), 32'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    clr();
    for (int i = 0; i < NR; i++) begin
      wb(1'b0, r_adr[i], 32'h0);
      chk32(rd, 32'h0);
      wb(1'b1, r_adr[i], r_wd[i]);
      wb(1'b0, r_adr[i], 32'h0);
      chk32(rd, r_rd[i]);
    end
    wb(1'b1, ADDR_CTRL, 32'h0000_00FF);
    wb(1'b1, ADDR_ALARM_DLY, 32'h0000_0002);
    wb(1'b1, ADDR_FAULT_DLY, 32'h0000_0000);
    wb(1'b1, ADDR_STAGE_EN, 32'h0000_0001);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0000_0040);
    clr();
    @(posedge clk) st_cmd <= 6'h11;
    cycles(3);
    chk32(32'(fl), 32'h0000_0009);
    chk32(32'(acc), 32'h0000_0041);
    chk1(irq, 1'b1);
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk1(rd[6], 1'b1);
    cycles(2);
    chk1(irq, 1'b0);
    // Repeated starts of one phase: suppressed first, then reported.
    @(posedge clk) st_cmd <= 6'h01;
    wb(1'b1, ADDR_STAGE_EN, 32'h0000_0003);
    clr();
    @(posedge clk) st_cmd <= 6'h09;
    cycles(3);
    chk32(32'(acc), 32'h0);
    @(posedge clk) st_cmd <= 6'h01;
    wb(1'b1, ADDR_CTRL, 32'h0000_01FF);
    clr();
    @(posedge clk) st_cmd <= 6'h09;
    cycles(3);
    chk32(32'(acc), 32'h0000_0041);
    @(posedge clk) st_cmd <= 6'h00;
    pulse_tick();
    cycles(4);
    chk1(fl[0], 1'b1);
    @(posedge clk) st_cmd <= 6'h01;
    @(posedge clk) st_cmd <= 6'h00;
    clr();
    pulse_tick();
    cycles(4);
    chk1(fl[0], 1'b1);
    pulse_tick();
    cycles(4);
    chk32(32'(fl), 32'h0);
    chk32(32'(acc), 32'h0000_0088);
    clr();
    @(posedge clk);
    tr_cmd <= 6'h02;
    cu_cmd <= 32'h0000_1234;
    cycles(3);
    chk32(32'(fl), 32'h0000_00A0);
    chk32(32'(latest), 32'h0000_1234);
    @(posedge clk) tr_cmd <= 6'h00;
    cycles(3);
    chk32(32'(fl), 32'h0);
    chk32(32'(acc), 32'h0000_D200);
    wb(1'b1, ADDR_LATEST_CUR, 32'h0000_BEEF);
    wb(1'b0, ADDR_LATEST_CUR, 32'h0);
    chk32(rd, 32'h0000_BEEF);
    chk32(32'(latest), 32'h0000_BEEF);
    // With every enable off the flags still move but no event appears.
    wb(1'b1, ADDR_CTRL, 32'h0);
    clr();
    @(posedge clk);
    st_cmd <= 6'h04;
    tr_cmd <= 6'h04;
    cycles(3);
    chk32(32'(fl), 32'h0000_00CC);
    @(posedge clk);
    st_cmd <= 6'h00;
    tr_cmd <= 6'h00;
    pulse_tick();
    pulse_tick();
    cycles(4);
    chk32(32'(fl), 32'h0);
    chk32(32'(acc), 32'h0);
    conclude();
  end
endmodule // combined_overcurrent_status_tb
